// ==== pkg/cpu_ctrl_pkg.sv ====
// package: constants, enumerations and shared helpers of the cpu control core
`default_nettype none
package cpu_ctrl_pkg;

  // ---------------------------------------------------------------
  // vectors and fixed pages
  // ---------------------------------------------------------------
  localparam logic [7:0] VEC_PAGE     = 8'hff;
  localparam logic [7:0] NMI_VEC_LO   = 8'hfa;
  localparam logic [7:0] RESET_VEC_LO = 8'hfc;
  localparam logic [7:0] IRQ_VEC_LO   = 8'hfe;
  localparam logic [7:0] VEC_HI_BIT   = 8'h01;
  localparam logic [7:0] STACK_PAGE   = 8'h01;
  localparam logic [7:0] ZERO_PAGE    = 8'h00;

  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [7:0]  SP_RESET    = 8'hff;
  localparam logic [7:0]  P_RESET     = 8'h24;
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [2:0]  INIT_CYCLES = 3'd6;

  // ---------------------------------------------------------------
  // status flag positions
  // ---------------------------------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_I = 2;
  localparam int FLAG_B = 4;
  localparam int FLAG_U = 5;
  localparam int FLAG_V = 6;
  localparam int FLAG_N = 7;

  // ---------------------------------------------------------------
  // opcode fields: operation in the high nibble, mode in the low one
  // ---------------------------------------------------------------
  localparam int OPC_OP_HI   = 7;
  localparam int OPC_OP_LO   = 4;
  localparam int OPC_MODE_HI = 3;
  localparam int OPC_MODE_LO = 0;

  // ---------------------------------------------------------------
  // bus cycle phase counter: two clocks per phase
  // ---------------------------------------------------------------
  localparam logic [1:0] PH1_END   = 2'd1;
  localparam logic [1:0] PH2_START = 2'd2;
  localparam logic [1:0] PH2_END   = 2'd3;

  typedef enum logic [3:0] {
    M_IMPL, M_ACC, M_IMM, M_ZP, M_ZPX, M_ZPY, M_ABS, M_ABSX,
    M_ABSY, M_INDX, M_INDY, M_REL, M_ABSIND, M_RSV0, M_RSV1, M_RSV2
  } mode_e;

  typedef enum logic [3:0] {
    OP_LOAD, OP_STORE, OP_ADD, OP_AND, OP_SHL, OP_LOADX, OP_LOADY, OP_JUMP,
    OP_BVS, OP_BEQ, OP_BNE, OP_BCC, OP_BRK, OP_RTI, OP_CLI, OP_SEI
  } op_e;

  typedef enum logic [4:0] {
    S_HOLD, S_RST_INIT, S_FETCH, S_IMPL, S_OP1, S_OP2, S_PTR_LO, S_PTR_HI,
    S_DATA, S_BRANCH, S_PUSH_H, S_PUSH_L, S_PUSH_P, S_VEC_LO, S_VEC_HI,
    S_PULL_P, S_PULL_L, S_PULL_H
  } state_e;

  // page-zero add, carry dropped
  function automatic logic [7:0] zp_add(input logic [7:0] base, input logic [7:0] idx);
    zp_add = base + idx;
  endfunction

endpackage
`default_nettype wire

// ==== rtl/cpu_control.sv ====
// cpu control core: bus sequencing, interrupts, reset and addressing
// Functional notes
// - pending nmi runs the interrupt entry after the instruction, mask flag ignored
// - nmi entry loads pc low from fffa and high from fffb
// - interrupt inputs sampled in phase 2; entry starts next phase 1 after instruction
// - falling edge of set-overflow input sets v, sampled at end of phase 1
// - sync high from phase 1 through the whole opcode fetch cycle only
// - ready low in the sync phase 1 freezes the core until ready high
// - no write transfers while cold start is held low
// - rising edge of cold start begins the reset sequence at once
// - six init cycles, then set i, load pc from fffc and fffd
// - read/write and sync valid while cold start is held low
// - read/write high for transfers in, low for transfers out
// - accumulator mode is one byte, works on a, no memory operand
// - immediate mode takes the operand from the second byte
// - absolute mode address is second byte low, third byte high
// - zero page mode uses second byte with high byte zero
// - zero page indexed adds index to second byte, carry dropped
// - absolute indexed adds x or y to the sixteen bit base
// - branches only, signed offset added to pc at next instruction
// - indexed indirect: second byte plus x, pointer pair read in page zero
// - indirect indexed: pointer low plus y, carry into pointer high
// - absolute indirect: read pc pair from the given address and successor
// - maskable entry pushes pc and status, then sets the mask flag
// - maskable entry loads pc low from fffe and high from ffff
// - no interrupt is recognized while ready is low
`default_nettype none
module cpu_control
  import cpu_ctrl_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        cold_start_n,
  input  wire logic        ready,
  input  wire logic        irq_n,
  input  wire logic        nmi_n,
  input  wire logic        set_overflow_n,
  input  wire logic [7:0]  data_in,
  output logic      [15:0] addr,
  output logic      [7:0]  data_out,
  output logic             data_oe,
  output logic             read_write,
  output logic             sync,
  output logic             phase2,
  output logic      [7:0]  status
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [4:0]  pin_meta;
  logic [4:0]  pin_sync;
  logic        cold_s;
  logic        rdy_s;
  logic        irq_s;
  logic        nmi_s;
  logic        so_s;
  logic        cold_prev;
  logic        cold_rise;
  logic [1:0]  phase_cnt;
  logic        cycle_end;
  logic        rdy_q;
  logic        so_prev;
  logic        nmi_prev;
  logic        irq_q;
  logic        nmi_pending;
  logic        advance;
  logic        take_int;
  state_e      state;
  state_e      end_state;
  logic [15:0] pc;
  logic [7:0]  sp;
  logic [7:0]  opcode;
  logic [7:0]  op_lo;
  logic [7:0]  op_hi;
  logic [7:0]  ptr_lo;
  logic [7:0]  ptr_hi;
  logic [7:0]  vec_sel;
  logic        brk_entry;
  logic [2:0]  init_cnt;
  logic [7:0]  a;
  logic [7:0]  x;
  logic [7:0]  y;
  logic [7:0]  p;
  mode_e       mode;
  op_e         op;
  logic [15:0] ea;
  logic [7:0]  zp_ptr;
  logic [15:0] rel_target;
  logic        taken;
  logic        exec_en;
  logic [8:0]  sum;
  logic [15:0] bus_addr;
  logic [7:0]  bus_dout;
  logic        bus_write;

  assign mode = mode_e'(opcode[OPC_MODE_HI:OPC_MODE_LO]);
  assign op   = op_e'(opcode[OPC_OP_HI:OPC_OP_LO]);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // two flops for every asynchronous control pin
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_meta <= 5'h1f;
      pin_sync <= 5'h1f;
    end else begin
      pin_meta <= {set_overflow_n, nmi_n, irq_n, ready, cold_start_n};
      pin_sync <= pin_meta;
    end
  end

  assign cold_s = pin_sync[0];
  assign rdy_s  = pin_sync[1];
  assign irq_s  = pin_sync[2];
  assign nmi_s  = pin_sync[3];
  assign so_s   = pin_sync[4];

  // ---------------------------------------------------------------
  // phase timing
  // ---------------------------------------------------------------
  // cold start edge detect; reset leaves prev low so a reset restarts too
  always_ff @(posedge clock) begin
    if (rst) begin
      cold_prev <= 1'b0;
    end else begin
      cold_prev <= cold_s;
    end
  end

  assign cold_rise = cold_s & ~cold_prev;

  // counts 0..1 as phase 1, 2..3 as phase 2; a cold start edge restarts it
  always_ff @(posedge clock) begin
    if (rst || cold_rise) begin
      phase_cnt <= 2'd0;
    end else begin
      phase_cnt <= phase_cnt + 2'd1;
    end
  end

  assign cycle_end = (phase_cnt == PH2_END);

  // ---------------------------------------------------------------
  // ready, overflow set and interrupt sampling
  // ---------------------------------------------------------------
  // ready is taken at the close of phase 1
  always_ff @(posedge clock) begin
    if (rst) begin
      rdy_q <= 1'b1;
    end else if (phase_cnt == PH1_END) begin
      rdy_q <= rdy_s;
    end
  end

  // overflow-set level sampled at the trailing edge of phase 1
  always_ff @(posedge clock) begin
    if (rst) begin
      so_prev <= 1'b1;
    end else if (phase_cnt == PH1_END) begin
      so_prev <= so_s;
    end
  end

  // interrupt lines sampled at the close of phase 2
  always_ff @(posedge clock) begin
    if (rst) begin
      nmi_prev <= 1'b1;
      irq_q    <= 1'b0;
    end else if (cycle_end) begin
      nmi_prev <= nmi_s;
      irq_q    <= ~irq_s;
    end
  end

  // nmi edge latch; a new edge wins over the clear on entry
  always_ff @(posedge clock) begin
    if (rst) begin
      nmi_pending <= 1'b0;
    end else if (cycle_end && nmi_prev && !nmi_s) begin
      nmi_pending <= 1'b1;
    end else if (advance && state == S_PUSH_P && vec_sel == NMI_VEC_LO) begin
      nmi_pending <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // sequencing decisions
  // ---------------------------------------------------------------
  // a read cycle waits while ready is low; writes never wait
  assign advance  = cycle_end & cold_s & (bus_write | rdy_q);
  // end of instruction: nmi regardless of mask, irq only when unmasked
  assign take_int = rdy_q & (nmi_pending | (irq_q & ~p[FLAG_I]));
  assign end_state = take_int ? S_PUSH_H : S_FETCH;

  // branch condition test
  always_comb begin
    case (op)
      OP_BVS:  taken = p[FLAG_V];
      OP_BEQ:  taken = p[FLAG_Z];
      OP_BNE:  taken = ~p[FLAG_Z];
      OP_BCC:  taken = ~p[FLAG_C];
      default: taken = 1'b0;
    endcase
  end

  ea_unit u_ea (
    .mode       (opcode[OPC_MODE_HI:OPC_MODE_LO]),
    .op_lo      (op_lo),
    .op_hi      (op_hi),
    .ptr_lo     (ptr_lo),
    .ptr_hi     (ptr_hi),
    .x          (x),
    .y          (y),
    .pc         (pc),
    .ea         (ea),
    .zp_ptr     (zp_ptr),
    .rel_target (rel_target)
  );

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // one state per bus cycle; moves on an accepted cycle end, or at once on a cold start change
  always_ff @(posedge clock) begin
    if (rst) begin
      state     <= S_HOLD;
      pc        <= PC_RESET;
      sp        <= SP_RESET;
      opcode    <= 8'h00;
      op_lo     <= 8'h00;
      op_hi     <= 8'h00;
      ptr_lo    <= 8'h00;
      ptr_hi    <= 8'h00;
      vec_sel   <= RESET_VEC_LO;
      brk_entry <= 1'b0;
      init_cnt  <= 3'd0;
    end else if (!cold_s) begin
      state <= S_HOLD;
    end else if (cold_rise) begin
      state    <= S_RST_INIT;
      init_cnt <= 3'd0;
    end else if (advance) begin
      case (state)
        S_HOLD: state <= S_RST_INIT;
        S_RST_INIT: begin
          init_cnt <= init_cnt + 3'd1;
          if (init_cnt == INIT_CYCLES - 3'd1) begin
            vec_sel <= RESET_VEC_LO;
            state   <= S_VEC_LO;
          end
        end
        S_FETCH: begin
          opcode    <= data_in;
          pc        <= pc + 16'd1;
          brk_entry <= 1'b0;
          case (mode_e'(data_in[OPC_MODE_HI:OPC_MODE_LO]))
            M_IMPL, M_ACC: state <= S_IMPL;
            default:       state <= S_OP1;
          endcase
        end
        S_IMPL: begin
          if (op == OP_BRK) begin
            brk_entry <= 1'b1;
            vec_sel   <= IRQ_VEC_LO;
            state     <= S_PUSH_H;
          end else if (op == OP_RTI) begin
            state <= S_PULL_P;
          end else begin
            vec_sel <= nmi_pending ? NMI_VEC_LO : IRQ_VEC_LO;
            state   <= end_state;
          end
        end
        S_OP1: begin
          op_lo <= data_in;
          pc    <= pc + 16'd1;
          vec_sel <= nmi_pending ? NMI_VEC_LO : IRQ_VEC_LO;
          case (mode)
            M_IMM:                    state <= end_state;
            M_REL:                    state <= taken ? S_BRANCH : end_state;
            M_ZP, M_ZPX, M_ZPY:       state <= S_DATA;
            M_INDX, M_INDY:           state <= S_PTR_LO;
            default:                  state <= S_OP2;
          endcase
        end
        S_OP2: begin
          op_hi <= data_in;
          pc    <= pc + 16'd1;
          if (mode == M_ABSIND) begin
            state <= S_PTR_LO;
          end else if (op == OP_JUMP) begin
            pc    <= {data_in, op_lo};
            state <= end_state;
          end else begin
            state <= S_DATA;
          end
        end
        S_PTR_LO: begin
          ptr_lo <= data_in;
          state  <= S_PTR_HI;
        end
        S_PTR_HI: begin
          ptr_hi <= data_in;
          if (mode == M_ABSIND) begin
            pc    <= {data_in, ptr_lo};
            state <= end_state;
          end else begin
            state <= S_DATA;
          end
        end
        S_DATA: state <= end_state;
        S_BRANCH: begin
          pc    <= rel_target;
          state <= end_state;
        end
        S_PUSH_H: begin
          // vector chosen at entry so a late nmi is not sent to the irq vector
          if (!brk_entry) begin
            vec_sel <= nmi_pending ? NMI_VEC_LO : IRQ_VEC_LO;
          end
          sp    <= sp - 8'd1;
          state <= S_PUSH_L;
        end
        S_PUSH_L: begin
          sp    <= sp - 8'd1;
          state <= S_PUSH_P;
        end
        S_PUSH_P: begin
          sp    <= sp - 8'd1;
          state <= S_VEC_LO;
        end
        S_VEC_LO: begin
          pc[7:0] <= data_in;
          state   <= S_VEC_HI;
        end
        S_VEC_HI: begin
          pc[15:8] <= data_in;
          state    <= S_FETCH;
        end
        S_PULL_P: begin
          sp    <= sp + 8'd1;
          state <= S_PULL_L;
        end
        S_PULL_L: begin
          sp      <= sp + 8'd1;
          pc[7:0] <= data_in;
          state   <= S_PULL_H;
        end
        S_PULL_H: begin
          sp       <= sp + 8'd1;
          pc[15:8] <= data_in;
          state    <= S_FETCH;
        end
        default: state <= S_HOLD;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // accumulator, index registers and status
  // ---------------------------------------------------------------
  assign exec_en = advance & ((state == S_IMPL) | ((state == S_OP1) & (mode == M_IMM)) |
                              ((state == S_DATA) & (op != OP_STORE)));
  assign sum     = {1'b0, a} + {1'b0, data_in} + {8'h00, p[FLAG_C]};

  // operations on the fetched operand; overflow-set edge wins last
  always_ff @(posedge clock) begin
    if (rst) begin
      a <= 8'h00;
      x <= 8'h00;
      y <= 8'h00;
      p <= P_RESET;
    end else begin
      if (exec_en) begin
        case (op)
          OP_LOAD: begin
            a         <= data_in;
            p[FLAG_N] <= data_in[7];
            p[FLAG_Z] <= (data_in == 8'h00);
          end
          OP_LOADX: begin
            x         <= data_in;
            p[FLAG_N] <= data_in[7];
            p[FLAG_Z] <= (data_in == 8'h00);
          end
          OP_LOADY: begin
            y         <= data_in;
            p[FLAG_N] <= data_in[7];
            p[FLAG_Z] <= (data_in == 8'h00);
          end
          OP_ADD: begin
            a         <= sum[7:0];
            p[FLAG_C] <= sum[8];
            p[FLAG_V] <= (a[7] == data_in[7]) & (sum[7] != a[7]);
            p[FLAG_N] <= sum[7];
            p[FLAG_Z] <= (sum[7:0] == 8'h00);
          end
          OP_AND: begin
            a         <= a & data_in;
            p[FLAG_N] <= a[7] & data_in[7];
            p[FLAG_Z] <= ((a & data_in) == 8'h00);
          end
          OP_SHL: begin
            a         <= {a[6:0], 1'b0};
            p[FLAG_C] <= a[7];
            p[FLAG_N] <= a[6];
            p[FLAG_Z] <= (a[6:0] == 7'h00);
          end
          OP_CLI:  p[FLAG_I] <= 1'b0;
          OP_SEI:  p[FLAG_I] <= 1'b1;
          default: ;
        endcase
      end
      if (advance && state == S_PULL_P) begin
        p <= {data_in[7:6], 1'b1, 1'b0, data_in[3:0]};
      end
      if (advance && state == S_VEC_LO) begin
        p[FLAG_I] <= 1'b1;
      end
      if (phase_cnt == PH1_END && so_prev && !so_s) begin
        p[FLAG_V] <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // bus cycle contents
  // ---------------------------------------------------------------
  always_comb begin
    bus_addr  = pc;
    bus_dout  = 8'h00;
    bus_write = 1'b0;
    case (state)
      S_PTR_LO: bus_addr = (mode == M_ABSIND) ? {op_hi, op_lo} : {ZERO_PAGE, zp_ptr};
      S_PTR_HI: bus_addr = (mode == M_ABSIND) ? {op_hi, op_lo} + 16'd1 :
                           {ZERO_PAGE, zp_add(zp_ptr, 8'h01)};
      S_DATA: begin
        bus_addr  = ea;
        bus_dout  = a;
        bus_write = (op == OP_STORE);
      end
      S_PUSH_H: begin
        bus_addr  = {STACK_PAGE, sp};
        bus_dout  = pc[15:8];
        bus_write = 1'b1;
      end
      S_PUSH_L: begin
        bus_addr  = {STACK_PAGE, sp};
        bus_dout  = pc[7:0];
        bus_write = 1'b1;
      end
      S_PUSH_P: begin
        bus_addr  = {STACK_PAGE, sp};
        bus_dout  = p | {3'b000, brk_entry, 4'h0};
        bus_write = 1'b1;
      end
      S_VEC_LO: bus_addr = {VEC_PAGE, vec_sel};
      S_VEC_HI: bus_addr = {VEC_PAGE, vec_sel | VEC_HI_BIT};
      S_PULL_P, S_PULL_L, S_PULL_H: bus_addr = {STACK_PAGE, sp + 8'd1};
      default: bus_addr = pc;
    endcase
    if (!cold_s) begin
      bus_write = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // registered pins
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      addr       <= 16'h0000;
      data_out   <= 8'h00;
      data_oe    <= 1'b0;
      read_write <= 1'b1;
      sync       <= 1'b0;
      phase2     <= 1'b0;
      status     <= P_RESET;
    end else begin
      addr       <= bus_addr;
      data_out   <= bus_dout;
      read_write <= ~bus_write;
      sync       <= (state == S_FETCH) & cold_s;
      phase2     <= (phase_cnt == PH1_END) | (phase_cnt == PH2_START);
      data_oe    <= bus_write & ((phase_cnt == PH1_END) | (phase_cnt == PH2_START));
      status     <= p;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/ea_unit.sv ====
// effective address unit: forms memory operand addresses for the zero page, absolute, (ind,x) and (ind),y modes
`default_nettype none
module ea_unit
  import cpu_ctrl_pkg::*;
(
  input  wire logic [3:0]  mode,
  input  wire logic [7:0]  op_lo,
  input  wire logic [7:0]  op_hi,
  input  wire logic [7:0]  ptr_lo,
  input  wire logic [7:0]  ptr_hi,
  input  wire logic [7:0]  x,
  input  wire logic [7:0]  y,
  input  wire logic [15:0] pc,
  output logic      [15:0] ea,
  output logic      [7:0]  zp_ptr,
  output logic      [15:0] rel_target
);

  logic [8:0] indy_lo;

  // ---------------------------------------------------------------
  // pointer and relative target
  // ---------------------------------------------------------------
  // page-zero pointer, x added without carry for indexed indirect
  assign zp_ptr     = (mode_e'(mode) == M_INDX) ? zp_add(op_lo, x) : op_lo;
  // signed offset against pc already at the next instruction
  assign rel_target = pc + {{8{op_lo[7]}}, op_lo};
  assign indy_lo    = {1'b0, ptr_lo} + {1'b0, y};

  // ---------------------------------------------------------------
  // effective address per mode
  // ---------------------------------------------------------------
  always_comb begin
    case (mode_e'(mode))
      M_ZP:    ea = {ZERO_PAGE, op_lo};
      M_ZPX:   ea = {ZERO_PAGE, zp_add(op_lo, x)};
      M_ZPY:   ea = {ZERO_PAGE, zp_add(op_lo, y)};
      M_ABS:   ea = {op_hi, op_lo};
      M_ABSX:  ea = {op_hi, op_lo} + {8'h00, x};
      M_ABSY:  ea = {op_hi, op_lo} + {8'h00, y};
      M_INDX:  ea = {ptr_hi, ptr_lo};
      M_INDY:  ea = {ptr_hi + {7'h00, indy_lo[8]}, indy_lo[7:0]};
      default: ea = {op_hi, op_lo};
    endcase
  end

endmodule
`default_nettype wire

// ==== tb/cpu_control_props.sv ====
// checker: bus and control relations at the core's ports
`default_nettype none
module cpu_control_props
  import cpu_ctrl_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        cold_start_n,
  input wire logic        set_overflow_n,
  input wire logic [15:0] addr,
  input wire logic        data_oe,
  input wire logic        read_write,
  input wire logic        sync,
  input wire logic        phase2,
  input wire logic [7:0]  status
);
  default clocking dc @(posedge clock); endclocking
  // a cold start aborts the bus cycle in flight, like a reset
  default disable iff (rst || !cold_start_n);
  a_oe_in_write: assert property (data_oe |-> !read_write && phase2)
    else $error("bus driven outside a write phase");
  a_oe_two_clk: assert property ($rose(data_oe) |=> data_oe ##1 !data_oe)
    else $error("write drive not two clocks");
  a_cold_no_write: assert property (disable iff (rst) (!cold_start_n)[*5] |-> !data_oe && read_write)
    else $error("write while cold start low");
  a_cold_no_sync: assert property (disable iff (rst) (!cold_start_n)[*5] |-> !sync)
    else $error("sync high while cold start low");
  a_fetch_is_read: assert property (sync |-> read_write)
    else $error("opcode fetch not a read");
  a_sync_whole: assert property ($rose(sync) |-> sync[*4])
    else $error("sync dropped inside fetch cycle");
  a_addr_hold: assert property (phase2 |-> $stable(addr) && $stable(read_write))
    else $error("address or direction moved in phase 2");
  a_ovf_set: assert property ($fell(set_overflow_n) |-> ##[1:16] status[FLAG_V])
    else $error("overflow flag not set");
endmodule
bind cpu_control cpu_control_props u_props (.clock(clock), .rst(rst), .cold_start_n(cold_start_n),
  .set_overflow_n(set_overflow_n), .addr(addr), .data_oe(data_oe), .read_write(read_write),
  .sync(sync), .phase2(phase2), .status(status));
`default_nettype wire

// ==== tb/mem_model.sv ====
// memory partner: byte store answering the core's bus cycles
`default_nettype none
module mem_model (
  input  wire logic        clock,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  data_out,
  input  wire logic        data_oe,
  output logic      [7:0]  data_in
);
  timeunit 1ns; timeprecision 1ps;
  logic [7:0] mem [65536];
  initial foreach (mem[i]) mem[i] = 8'h00;
  // read data follows the address
  assign data_in = mem[addr];
  // store while the core drives the bus
  always @(posedge clock) if (data_oe) mem[addr] <= data_out;
endmodule
`default_nettype wire

// ==== tb/tb_cpu_control.sv ====
// testbench: program, interrupt and cold start runs through the core
`default_nettype none
module tb_cpu_control;
  import cpu_ctrl_pkg::*;
  timeunit 1ns; timeprecision 1ps;
  logic        clock, rst, cold_start_n, ready, irq_n, nmi_n, set_overflow_n;
  logic [7:0]  data_in, data_out, status;
  logic [15:0] addr;
  logic        data_oe, read_write, sync, phase2;
  int          error_cnt = 0;
  int          cmp_count = 0;
  bit          seen [logic [15:0]];
  cpu_control DUT (.clock(clock), .rst(rst), .cold_start_n(cold_start_n), .ready(ready), .irq_n(irq_n),
    .nmi_n(nmi_n), .set_overflow_n(set_overflow_n), .data_in(data_in), .addr(addr), .data_out(data_out),
    .data_oe(data_oe), .read_write(read_write), .sync(sync), .phase2(phase2), .status(status));
  mem_model mem_i (.clock(clock), .addr(addr), .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // note every opcode fetch address
  always @(negedge clock) if (sync && phase2) seen[addr] = 1'b1;
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic see(input logic [15:0] a);
    for (int n = 0; n < 3000 && !seen.exists(a); n++) @(negedge clock);
    chk("fetch", a, seen.exists(a) ? a : 16'hxxxx);
  endtask
  task automatic put(input logic [15:0] a, input logic [7:0] b[$]);
    foreach (b[i]) mem_i.mem[a + 16'(i)] = b[i];
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic t_modes();
    logic [15:0] a[7] = '{16'h1234, 16'h0040, 16'h0001, 16'h1302, 16'h3000, 16'h3103, 16'h3100};
    see(16'h0200);
    chk("mask", 16'h1, 16'(status[FLAG_I]));
    see(16'h0500);
    see(16'h0581);
    see(16'h0504);
    foreach (a[i]) chk("store", i == 6 ? 16'h00b4 : 16'h005a, 16'(mem_i.mem[a[i]]));
    $display("addressing test done");
  endtask
  task automatic t_irq();
    logic [15:0] a0;
    ready = 1'b0;
    irq_n = 1'b0;
    repeat (40) @(negedge clock);
    a0 = addr;
    repeat (100) @(negedge clock);
    chk("frozen addr", a0, addr);
    chk("no entry", 16'h0, 16'(seen.exists(16'h0600)));
    ready = 1'b1;
    see(16'h0600);
    irq_n = 1'b1;
    chk("push hi", 16'h05, 16'(mem_i.mem[16'h01ff]));
    chk("push lo", 16'h04, 16'(mem_i.mem[16'h01fe]));
    chk("mask", 16'h1, 16'(status[FLAG_I]));
    nmi_n = 1'b0;
    see(16'h0700);
    chk("nmi push hi", 16'h06, 16'(mem_i.mem[16'h01fc]));
    nmi_n = 1'b1;
    $display("interrupt test done");
  endtask
  task automatic t_ctrl();
    set_overflow_n = 1'b0;
    repeat (20) @(negedge clock);
    chk("overflow", 16'h1, 16'(status[FLAG_V]));
    set_overflow_n = 1'b1;
    cold_start_n = 1'b0;
    repeat (12) @(negedge clock);
    chk("cold rw", 16'h1, 16'(read_write));
    chk("cold sync", 16'h0, 16'(sync));
    seen.delete();
    cold_start_n = 1'b1;
    see(16'h0200);
    $display("control pin test done");
  endtask
  initial begin
    rst = 1'b1;
    cold_start_n = 1'b0;
    ready = 1'b1;
    irq_n = 1'b1;
    nmi_n = 1'b1;
    set_overflow_n = 1'b1;
    @(negedge clock);
    put(16'hfffa, '{8'h00, 8'h07, 8'h00, 8'h02, 8'h00, 8'h06});
    put(16'h0200, '{8'h02, 8'h5a, 8'h16, 8'h34, 8'h12, 8'h13, 8'h40, 8'h52, 8'h03, 8'h14, 8'hfe, 8'h17,
                    8'hff, 8'h12, 8'h62, 8'h05, 8'h19, 8'h10, 8'h1a, 8'h20, 8'h41, 8'h16, 8'h00, 8'h31,
                    8'h7c, 8'h00, 8'h40});
    put(16'h0013, '{8'h00, 8'h30});
    put(16'h0020, '{8'hfe, 8'h30});
    put(16'h4000, '{8'h00, 8'h05});
    put(16'h0500, '{8'hab, 8'h7f, 8'h00, 8'he0, 8'h76, 8'h04, 8'h05});
    put(16'h0581, '{8'hab, 8'h80});
    put(16'h0600, '{8'h76, 8'h00, 8'h06});
    put(16'h0700, '{8'h76, 8'h00, 8'h07});
    repeat (7) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    cold_start_n = 1'b1;
    t_modes();
    t_irq();
    t_ctrl();
    print_verdict();
  end
  // watchdog against a hung core
  initial begin
    repeat (40000) @(posedge clock);
    error_cnt++;
    print_verdict();
  end
endmodule
`default_nettype wire
